// ### verilog/serial_port_device.sv
// Operation
// (R1) Every word shifts most significant bit first
// (R2) Eight address bits, then eight data bits
// (R3) Data output driven only while read selected
// (R4) Sample data on serial clock rising edge
// (R5) Serial pins synchronised before any logic
// (R6) Serial clock at most half master rate
// (R7) Read/write select stable before rising edge
// (R8) Chip select high: other port inputs ignored
// (R9) Chip select affects no other device output
// (R10) Unused three-wire input held at level
// (R11) Reset disables transceiver, long reset standby
// (R12) Reset leaves configuration registers untouched
// (R13) Controller programs registers after power-up
// (R14) Internal clocks divide master by two, four
// (R15) Address least significant bit is ignored
// (R16) Chip select high resets port state
// (R17) Rising edge samples and launches read data; the controller takes read bits at the following fall
// (R18) Program only with clock running, reset off
// (R19) Write commits only after all sixteen bits
module serial_port_device (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Serial pins
  serial_port_if.device port,
  // Configuration read port for the core logic
  input wire logic [serial_port_pkg::REG_IDX_W-1:0] cfg_idx_i,
  output logic [serial_port_pkg::DATA_W-1:0] cfg_data_o,
  // Write event and last written index
  output logic cfg_write_o,
  output logic [serial_port_pkg::REG_IDX_W-1:0] cfg_write_idx_o,
  // Transceiver control
  output logic txrx_enable_o,
  output logic standby_o,
  output logic clk_div2_o,
  output logic clk_div4_o
);

  // Two-stage synchronisers, plus a third sclk stage for edge finding
  logic sclk_s1_ff;
  logic sclk_s2_ff;
  logic sclk_s3_ff;
  logic cs_n_s1_ff;
  logic cs_n_s2_ff;
  logic rw_s1_ff;
  logic rw_s2_ff;
  logic sd_s1_ff;
  logic sd_s2_ff;

  // Transfer state
  logic [3:0] bit_cnt_ff;
  logic [serial_port_pkg::ADDR_W-1:0] addr_ff;
  logic [serial_port_pkg::DATA_W-1:0] data_ff;
  logic [serial_port_pkg::DATA_W-1:0] out_ff;
  logic write_ff;
  logic [serial_port_pkg::REG_IDX_W-1:0] write_idx_ff;

  // Configuration storage, no reset
  logic [serial_port_pkg::DATA_W-1:0] regs_ff [serial_port_pkg::REG_COUNT];

  // Transceiver control state
  logic [1:0] div_ff;
  logic enable_ff;
  logic standby_ff;
  logic [4:0] hold_cnt_ff;
  logic [4:0] nxt_hold_cnt;

  // Decoded strobes
  logic sclk_rise;
  logic addr_phase;
  logic addr_done;
  logic write_done;
  logic [serial_port_pkg::ADDR_W-1:0] nxt_addr;
  logic [serial_port_pkg::DATA_W-1:0] nxt_data;
  logic [serial_port_pkg::REG_IDX_W-1:0] rd_idx;

  // Synchronise every serial pin before use
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sclk_s1_ff <= 1'h0;
      sclk_s2_ff <= 1'h0;
      sclk_s3_ff <= 1'h0;
      cs_n_s1_ff <= 1'h1;
      cs_n_s2_ff <= 1'h1;
      rw_s1_ff <= 1'h0;
      rw_s2_ff <= 1'h0;
      sd_s1_ff <= 1'h0;
      sd_s2_ff <= 1'h0;
    end else begin
      sclk_s1_ff <= port.sclk; // R5
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      cs_n_s1_ff <= port.cs_n;
      cs_n_s2_ff <= cs_n_s1_ff;
      rw_s1_ff <= port.rw;
      rw_s2_ff <= rw_s1_ff;
      sd_s1_ff <= port.serial_io_line;
      sd_s2_ff <= sd_s1_ff;
    end
  end

  // Rising serial clock counts only while selected
  assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff & ~cs_n_s2_ff; // R4 R8
  assign addr_phase = ~bit_cnt_ff[3]; // R2
  assign addr_done = sclk_rise & (bit_cnt_ff == serial_port_pkg::LAST_ADDR_BIT);
  assign write_done = sclk_rise & (bit_cnt_ff == serial_port_pkg::LAST_DATA_BIT) & ~rw_s2_ff; // R19
  assign nxt_addr = {addr_ff[serial_port_pkg::ADDR_W-2:0], sd_s2_ff}; // R1
  assign nxt_data = {data_ff[serial_port_pkg::DATA_W-2:0], sd_s2_ff}; // R1
  // Index drops the address LSB; at the last address bit it is addr_ff[6:0]
  assign rd_idx = addr_ff[serial_port_pkg::REG_IDX_W-1:0]; // R15

  // Bit counter and shift registers, cleared while chip select is high
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || cs_n_s2_ff) begin
      bit_cnt_ff <= 4'h0; // R16
      addr_ff <= 8'h00;
      data_ff <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (addr_phase) begin
        addr_ff <= nxt_addr;
      end else begin
        data_ff <= nxt_data;
      end
    end
  end

  // Read data launches on the rising edge, MSB first
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || cs_n_s2_ff) begin
      out_ff <= 8'h00;
    end else if (addr_done) begin
      out_ff <= regs_ff[rd_idx]; // R17
    end else if (sclk_rise && !addr_phase) begin
      out_ff <= {out_ff[serial_port_pkg::DATA_W-2:0], 1'h0}; // R1 R17
    end
  end

  // Register file commits a write only on the sixteenth rising edge
  always_ff @(posedge sys_clk_i) begin
    if (write_done) begin
      regs_ff[addr_ff[serial_port_pkg::ADDR_W-1:1]] <= nxt_data; // R12 R15 R19
    end
  end

  // Write event for the core
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      write_ff <= 1'h0;
      write_idx_ff <= 7'h00;
    end else begin
      write_ff <= write_done;
      if (write_done) begin
        write_idx_ff <= addr_ff[serial_port_pkg::ADDR_W-1:1];
      end
    end
  end

  // Data line driven only while read is selected and chip is selected
  assign port.dev_sd_o = out_ff[serial_port_pkg::DATA_W-1];
  // Held off through the address phase, when the controller owns the line
  assign port.dev_sd_oe = rw_s2_ff & ~cs_n_s2_ff & ~addr_phase; // R3 R8

  // Configuration readout for the core
  assign cfg_data_o = regs_ff[cfg_idx_i];
  assign cfg_write_o = write_ff;
  assign cfg_write_idx_o = write_idx_ff;

  // Reset hold counter for standby entry
  assign nxt_hold_cnt = (hold_cnt_ff == serial_port_pkg::STANDBY_HOLD_CYCLES) ? hold_cnt_ff : hold_cnt_ff + 5'h01;

  // Transceiver enable and standby, independent of chip select
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      enable_ff <= 1'h0; // R11 R9
      hold_cnt_ff <= nxt_hold_cnt;
      standby_ff <= (nxt_hold_cnt == serial_port_pkg::STANDBY_HOLD_CYCLES); // R11
    end else begin
      enable_ff <= 1'h1;
      hold_cnt_ff <= 5'h00;
      standby_ff <= 1'h0;
    end
  end

  // Divided transceiver clocks from the master clock
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1; // R14
    end
  end

  // Transceiver outputs
  assign txrx_enable_o = enable_ff;
  assign standby_o = standby_ff;
  assign clk_div2_o = div_ff[0]; // R14
  assign clk_div4_o = div_ff[1]; // R14

endmodule

// ### verilog/serial_port_pkg.sv
package serial_port_pkg;

  // Word and transfer layout
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int XFER_BITS = 16;
  localparam logic [3:0] LAST_ADDR_BIT = 4'h7;
  localparam logic [3:0] LAST_DATA_BIT = 4'hF;
  localparam logic [4:0] FIRST_DATA_RISE = 5'h08;
  localparam logic [4:0] LAST_RISE = 5'h0F;

  // Register file: address LSB is ignored, so the index is the upper seven bits
  localparam int REG_IDX_W = 7;
  localparam int REG_COUNT = 128;

  // Timing, master clock period and serial clock half period
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int SCLK_HALF_NS = 800;
  localparam logic [3:0] SCLK_HALF_CYCLES = 4'((SCLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

  // Reset held this long puts the device into standby
  localparam int STANDBY_HOLD_NS = 1600;
  localparam logic [4:0] STANDBY_HOLD_CYCLES = 5'((STANDBY_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

  // Level the controller keeps on the unused three-wire input
  localparam logic THREE_WIRE_LEVEL = 1'h0;

endpackage

// ### verilog/serial_port_if.sv
interface serial_port_if;

  // Pins driven by the controller
  logic sclk;
  logic cs_n;
  logic rw;
  logic three_wire_input;
  logic ctl_sd_o;
  logic ctl_sd_oe;

  // Pins driven by the device
  logic dev_sd_o;
  logic dev_sd_oe;

  // Resolved level of the shared data line, pulled high when nobody drives
  logic serial_io_line;
  assign serial_io_line = dev_sd_oe ? dev_sd_o : (ctl_sd_oe ? ctl_sd_o : 1'h1);

  modport device (
    input sclk,
    input cs_n,
    input rw,
    input three_wire_input,
    input serial_io_line,
    output dev_sd_o,
    output dev_sd_oe
  );

  modport controller (
    output sclk,
    output cs_n,
    output rw,
    output three_wire_input,
    output ctl_sd_o,
    output ctl_sd_oe,
    input serial_io_line
  );

endinterface

// ### verilog/serial_port_controller.sv
module serial_port_controller (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Serial pins
  serial_port_if.controller port,
  // Request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [serial_port_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [serial_port_pkg::DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  // Answer
  output logic done_o,
  output logic [serial_port_pkg::DATA_W-1:0] rdata_o
);

  typedef enum logic [2:0] {IDLE, SETUP, HIGH, LOW, HOLD} state_type;

  state_type state_ff;
  logic [3:0] timer_ff;
  logic [4:0] rise_cnt_ff;
  logic [serial_port_pkg::XFER_BITS-1:0] shift_ff;
  logic [serial_port_pkg::DATA_W-1:0] rd_ff;
  logic write_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic done_ff;
  logic sd_s1_ff;
  logic sd_s2_ff;
  logic half_done;
  logic sample_now;
  logic last_addr_bit;
  logic addr_drive;

  // Half-period timer expiry and read sampling point
  assign half_done = (timer_ff == serial_port_pkg::SCLK_HALF_CYCLES - 4'h1); // R6
  // Read bits launch on rises 8 to 15 and are taken at the fall that follows each
  assign sample_now = !write_ff && (rise_cnt_ff >= serial_port_pkg::FIRST_DATA_RISE - 5'h01)
    && (rise_cnt_ff != serial_port_pkg::LAST_RISE); // R17
  // Address LSB is held through its sampling rise, then the line is handed over
  assign last_addr_bit = (rise_cnt_ff == serial_port_pkg::FIRST_DATA_RISE - 5'h01);
  assign addr_drive = (rise_cnt_ff < serial_port_pkg::FIRST_DATA_RISE - 5'h01)
    || (last_addr_bit && (state_ff != HIGH || timer_ff == 4'h0));

  // Synchronise returning data line
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sd_s1_ff <= 1'h1;
      sd_s2_ff <= 1'h1;
    end else begin
      sd_s1_ff <= port.serial_io_line;
      sd_s2_ff <= sd_s1_ff;
    end
  end

  // Transfer sequencer: drive on falling edge, sample read before it
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_ff <= IDLE;
      timer_ff <= 4'h0;
      rise_cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
      rd_ff <= 8'h00;
      write_ff <= 1'h0;
      sclk_ff <= 1'h0;
      cs_n_ff <= 1'h1;
      done_ff <= 1'h0;
    end else begin
      done_ff <= 1'h0;
      timer_ff <= half_done ? 4'h0 : timer_ff + 4'h1;
      case (state_ff)
        IDLE: begin
          timer_ff <= 4'h0;
          if (req_valid_i) begin
            shift_ff <= {req_addr_i, req_wdata_i}; // R2
            write_ff <= req_write_i;
            rise_cnt_ff <= 5'h00;
            cs_n_ff <= 1'h0; // R16
            state_ff <= SETUP;
          end
        end
        SETUP, LOW: begin
          if (half_done) begin
            sclk_ff <= 1'h1;
            state_ff <= HIGH;
          end
        end
        HIGH: begin
          if (half_done) begin
            sclk_ff <= 1'h0;
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
            shift_ff <= {shift_ff[serial_port_pkg::XFER_BITS-2:0], 1'h0}; // R1
            if (sample_now) begin
              rd_ff <= {rd_ff[serial_port_pkg::DATA_W-2:0], sd_s2_ff}; // R1
            end
            state_ff <= (rise_cnt_ff == serial_port_pkg::LAST_RISE) ? HOLD : LOW;
          end
        end
        HOLD: begin
          if (half_done) begin
            cs_n_ff <= 1'h1; // R16
            done_ff <= 1'h1;
            state_ff <= IDLE;
          end
        end
        default: begin
          state_ff <= IDLE;
        end
      endcase
    end
  end

  // Pin drive: address always, data only for a write
  assign port.sclk = sclk_ff;
  assign port.cs_n = cs_n_ff;
  assign port.rw = !write_ff && !cs_n_ff; // R7
  assign port.three_wire_input = serial_port_pkg::THREE_WIRE_LEVEL; // R10
  assign port.ctl_sd_o = shift_ff[serial_port_pkg::XFER_BITS-1];
  assign port.ctl_sd_oe = !cs_n_ff && (write_ff || addr_drive);

  // User side
  assign req_ready_o = (state_ff == IDLE) && !reset_i; // R18
  assign done_o = done_ff;
  assign rdata_o = rd_ff;

endmodule

// ### testbench/serial_port_assertions.sv
module serial_port_assertions (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rw,
  input wire logic three_wire_input,
  input wire logic ctl_sd_o,
  input wire logic ctl_sd_oe,
  input wire logic dev_sd_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // Counts serial clock rises within one frame
  logic sclk_ff;
  logic [4:0] rise_ff;
  always_ff @(posedge sys_clk_i) begin
    sclk_ff <= sclk;
    rise_ff <= (reset_i || cs_n) ? 5'h00 : rise_ff + 5'(sclk && !sclk_ff);
  end

  a_frame_sixteen: assert property ($rose(cs_n) |-> rise_ff == 5'h10)
    else $error("frame rise count wrong");
  a_first_rise: assert property ($fell(cs_n) |-> ##8 $rose(sclk))
    else $error("first rise misplaced");
  a_sclk_high: assert property ($rose(sclk) |=> sclk [*7])
    else $error("serial clock high too short");
  a_sclk_low: assert property ($fell(sclk) |=> !sclk [*7])
    else $error("serial clock low too short");
  a_sclk_gated: assert property ($changed(sclk) |-> !cs_n)
    else $error("serial clock moved while deselected");
  a_rw_steady: assert property (!cs_n && !$past(cs_n) |-> $stable(rw))
    else $error("direction changed in frame");
  a_bit_stable: assert property ($rose(sclk) && ctl_sd_oe |-> $stable(ctl_sd_o))
    else $error("data moved at sampling rise");
  a_oe_read_only: assert property (dev_sd_oe |-> rw || $past(rw, 4))
    else $error("device drove line outside read");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:4] !dev_sd_oe)
    else $error("device kept line after frame");
  a_three_wire: assert property (three_wire_input == serial_port_pkg::THREE_WIRE_LEVEL)
    else $error("unused input not held");
  a_no_contention: assert property (!(dev_sd_oe && ctl_sd_oe))
    else $error("both ends drove the data line");

  // Main scenarios
  c_read: cover property ($rose(dev_sd_oe));
  c_write: cover property ($fell(cs_n) && !rw);
  c_frame_end: cover property ($rose(cs_n));
endmodule

// ### testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic req_valid_i = 1'h0;
  logic req_write_i = 1'h0;
  logic [7:0] req_addr_i = 8'h00;
  logic [7:0] req_wdata_i = 8'h00;
  logic [6:0] cfg_idx_i = 7'h00;
  logic req_ready_o, done_o, cfg_write_o, txrx_enable_o, standby_o, clk_div2_o, clk_div4_o;
  logic [7:0] rdata_o, cfg_data_o;
  logic [6:0] cfg_write_idx_o;
  int fail_count = 0;
  int num_checks = 0;
  int writes = 0;

  serial_port_if link ();
  serial_port_device serial_port_device_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .port(link),
    .cfg_idx_i(cfg_idx_i), .cfg_data_o(cfg_data_o), .cfg_write_o(cfg_write_o), .cfg_write_idx_o(cfg_write_idx_o),
    .txrx_enable_o(txrx_enable_o), .standby_o(standby_o), .clk_div2_o(clk_div2_o), .clk_div4_o(clk_div4_o));
  serial_port_controller serial_port_controller_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .port(link),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o));
  serial_port_assertions serial_port_assertions_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .rw(link.rw), .three_wire_input(link.three_wire_input), .ctl_sd_o(link.ctl_sd_o),
    .ctl_sd_oe(link.ctl_sd_oe), .dev_sd_oe(link.dev_sd_oe));

  // Clock
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Counts committed writes
  always @(negedge sys_clk_i) if (!reset_i && cfg_write_o === 1'h1) writes++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One controller transfer, bounded wait for done
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    int n;
    @(negedge sys_clk_i);
    req_valid_i = 1'h1;
    req_write_i = wr;
    req_addr_i = addr;
    req_wdata_i = data;
    @(negedge sys_clk_i);
    req_valid_i = 1'h0;
    for (n = 0; n < 400 && done_o !== 1'h1; n++) @(negedge sys_clk_i);
    if (n == 400) begin
      fail_count++;
      $display("[FAIL] %0t transfer timed out got %h exp %h", $time, done_o, 1'h1);
    end
  endtask

  // Write, then read back with the address low bit flipped
  task automatic test_rw();
    logic [7:0] addr [3] = '{8'h42, 8'hFF, 8'h00};
    logic [7:0] data [3] = '{8'hA5, 8'h01, 8'h80};
    for (int i = 0; i < 3; i++) begin
      xfer(1'h1, addr[i], data[i]);
      cfg_idx_i = addr[i][7:1];
      #1 check(cfg_data_o, data[i]);
      check({1'h0, cfg_write_idx_o}, {1'h0, addr[i][7:1]});
      xfer(1'h0, addr[i] ^ 8'h01, 8'h00);
      check(rdata_o, data[i]);
      check(8'(writes), 8'(i + 1));
      check({7'h00, txrx_enable_o}, 8'h01);
    end
  endtask

  // Long reset: standby, transceiver off, registers kept
  task automatic test_reset();
    @(negedge sys_clk_i);
    reset_i = 1'h1;
    repeat (20) @(negedge sys_clk_i);
    check({5'h00, req_ready_o, txrx_enable_o, standby_o}, 8'h01);
    reset_i = 1'h0;
    repeat (2) @(negedge sys_clk_i);
    check({7'h00, txrx_enable_o}, 8'h01);
    cfg_idx_i = 7'h21;
    #1 check(cfg_data_o, 8'hA5);
  endtask

  // Master clock dividers
  task automatic test_div();
    logic d2, d4;
    @(negedge sys_clk_i);
    d2 = clk_div2_o;
    d4 = clk_div4_o;
    @(negedge sys_clk_i);
    check({7'h00, clk_div2_o}, {7'h00, ~d2});
    @(negedge sys_clk_i);
    check({7'h00, clk_div2_o}, {7'h00, d2});
    check({7'h00, clk_div4_o}, {7'h00, ~d4});
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge sys_clk_i);
    reset_i = 1'h0;
    @(negedge sys_clk_i);
    check({5'h00, req_ready_o, txrx_enable_o, standby_o}, 8'h06);
    test_div();
    test_rw();
    test_reset();
    test_done();
  end
endmodule
